// File: rtl/cbmi_bus_mux.sv
// Processor bus clocking, reset, decode and shared address/data pin multiplexer
// Operation
// - The low address byte and the data byte share one group of eight pins each cycle.
// - The external buffer, when enabled, passes the low address byte onto the shared pins.
// - A disabled address buffer floats its outputs so data may use the shared pins.
// - The address buffer is switched off while the phase-two clock is high.
// - Sixteen bus pins carry the shared low group plus the eight upper address bits.
// - Control pins make the phase-two clock, processor reset and chip selects, and sample the strobe.
// - The address alone is decoded to pick the responding device each cycle; the read/write strobe only gates ROM data.
// - The core starts on its internal oscillator, then runs from a 5 MHz reference times 16.
// - At startup any serial download is waited out first, then a 32 KB image is always copied from EEPROM.
// - The loaded image holds the processor ROM, which the controller serves on the bus.
// - A reset pulse is applied to the processor at startup.
// - The static RAM gets the phase-two clock and a chip select only for its own addresses.
`timescale 1ns/10ps
`default_nettype none
`include "cbmi_defines.svh"
module cbmi_bus_mux
  import cbmi_pkg::*;
#(
  parameter int PHASE_HALF_CYC = `CBMI_PHASE_HALF_CYC,
  parameter int RESET_PULSE_CYC = `CBMI_RESET_PULSE_CYC,
  parameter int BOOT_WAIT_CYC = `CBMI_BOOT_WAIT_CYC,
  parameter int IMAGE_BYTES = `CBMI_IMAGE_BYTES,
  parameter int ROM_BYTES = 8192
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic core_clock_locked_in,
  input wire logic download_active_in,
  input wire logic image_valid_in,
  input wire logic [7:0] image_byte_in,
  output logic image_req_out,
  output logic [14:0] image_addr_out,
  input wire logic [7:0] shared_addr_data_pin_low_in,
  output logic [7:0] shared_addr_data_pin_low_out,
  output logic shared_addr_data_oe_out,
  input wire logic [7:0] bus_pin_group_top_in,
  input wire logic cpu_read_write_strobe_in,
  output logic cpu_phase_two_clock_out,
  output logic cpu_reset_n_out,
  output logic addr_buffer_enable_n_out,
  output logic sram_select_n_out,
  output logic io_select_n_out,
  output logic boot_done_out
);
  localparam int ROM_AW = $clog2(ROM_BYTES);
  localparam logic [15:0] ROM_BASE = `CBMI_ROM_BASE;
  localparam logic [15:0] SRAM_TOP = `CBMI_SRAM_TOP;
  localparam logic [15:0] IO_BASE = `CBMI_IO_BASE;
  localparam logic [15:0] IO_TOP = `CBMI_IO_TOP;

  function automatic cbmi_target_t decode(input logic [15:0] addr);
    if (addr <= SRAM_TOP)
      decode = CBMI_TGT_SRAM;
    else if (addr >= IO_BASE && addr <= IO_TOP)
      decode = CBMI_TGT_IO;
    else if (addr >= ROM_BASE)
      decode = CBMI_TGT_ROM;
    else
      decode = CBMI_TGT_NONE;
  endfunction : decode

  // Pin inputs cross into clk_in through two flops
  logic [7:0] low_sync;
  logic [7:0] high_sync;
  logic [2:0] ctl_sync;
  cbmi_sync #(.WIDTH(8)) u_low_sync (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .async_in(shared_addr_data_pin_low_in), .sync_out(low_sync)
  );
  cbmi_sync #(.WIDTH(8)) u_high_sync (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .async_in(bus_pin_group_top_in), .sync_out(high_sync)
  );
  cbmi_sync #(.WIDTH(3)) u_ctl_sync (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .async_in({cpu_read_write_strobe_in, download_active_in, core_clock_locked_in}),
    .sync_out(ctl_sync)
  );
  logic rw_s;
  logic dl_s;
  logic lock_s;
  assign rw_s = ctl_sync[2];
  assign dl_s = ctl_sync[1];
  assign lock_s = ctl_sync[0];

  // ROM image copied from the boot EEPROM
  logic [7:0] rom_mem [0:ROM_BYTES-1];

  cbmi_state_t state;
  cbmi_state_t next_state;
  logic [31:0] count;
  logic [31:0] next_count;
  logic [14:0] copy_addr;
  logic [14:0] next_copy_addr;
  logic image_req;
  logic next_image_req;
  logic cpu_reset_n;
  logic next_cpu_reset_n;

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_copy_addr = copy_addr;
    next_image_req = 1'b0;
    next_cpu_reset_n = 1'b0;
    case (state)
      CBMI_ST_BOOT_WAIT:
      begin
        // Hold off until the multiplied core clock is stable and no download runs
        if (!lock_s || dl_s)
          next_count = '0;
        else if (count >= 32'(BOOT_WAIT_CYC - 1))
        begin
          next_state = CBMI_ST_COPY;
          next_count = '0;
        end
        else
          next_count = count + 32'd1;
      end
      CBMI_ST_COPY:
      begin
        next_image_req = 1'b1;
        if (image_req && image_valid_in)
        begin
          next_copy_addr = copy_addr + 15'd1;
          if (32'(copy_addr) == 32'(IMAGE_BYTES - 1))
          begin
            next_state = CBMI_ST_RESET;
            next_image_req = 1'b0;
          end
        end
      end
      CBMI_ST_RESET:
      begin
        if (count >= 32'(RESET_PULSE_CYC - 1))
        begin
          next_state = CBMI_ST_RUN;
          next_count = '0;
        end
        else
          next_count = count + 32'd1;
      end
      CBMI_ST_RUN:
        next_cpu_reset_n = 1'b1;
      default:
        next_state = CBMI_ST_BOOT_WAIT;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= CBMI_ST_BOOT_WAIT;
      count <= '0;
      copy_addr <= '0;
      image_req <= 1'b0;
      cpu_reset_n <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      copy_addr <= next_copy_addr;
      image_req <= next_image_req;
      cpu_reset_n <= next_cpu_reset_n;
    end
  end

  // Top of the image is the processor ROM; no reset, so it maps to plain RAM
  always_ff @(posedge clk_in)
  begin
    if (state == CBMI_ST_COPY && image_req && image_valid_in
        && copy_addr >= 15'(IMAGE_BYTES - ROM_BYTES))
      rom_mem[copy_addr[ROM_AW-1:0]] <= image_byte_in;
  end

  // Bus phase generator
  cbmi_phase_t phase;
  cbmi_phase_t next_phase;
  logic [15:0] ph_count;
  logic [15:0] next_ph_count;
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic rw;
  logic next_rw;
  cbmi_target_t tgt;
  cbmi_target_t next_tgt;
  logic [7:0] rd_data;
  logic [7:0] next_rd_data;
  logic drive;
  logic next_drive;
  logic running;
  assign running = (state == CBMI_ST_RUN);

  always_comb
  begin
    next_phase = phase;
    next_ph_count = ph_count + 16'd1;
    next_addr = addr;
    next_rw = rw;
    next_tgt = tgt;
    next_rd_data = rd_data;
    next_drive = 1'b0;
    if (!running)
    begin
      next_phase = CBMI_PH_LOW;
      next_ph_count = '0;
      next_tgt = CBMI_TGT_NONE;
    end
    else if (ph_count == 16'(PHASE_HALF_CYC - 1))
    begin
      next_ph_count = '0;
      if (phase == CBMI_PH_LOW)
      begin
        // Address sits on the pins only in the low half, so it is sampled late in the low half
        next_phase = CBMI_PH_HIGH;
        next_addr = {high_sync, low_sync};
        next_rw = rw_s;
        next_tgt = decode({high_sync, low_sync});
      end
      else
      begin
        next_phase = CBMI_PH_LOW;
        next_tgt = CBMI_TGT_NONE;
      end
    end
    // Drive ROM data in the high half, dropping early so it clears before the fall
    if (running && phase == CBMI_PH_HIGH && tgt == CBMI_TGT_ROM && rw
        && ph_count < 16'(PHASE_HALF_CYC - 1 - `CBMI_DATA_RELEASE_CYC))
      next_drive = 1'b1;
    // Fetch from the captured address, ready by the first driven cycle
    if (running && phase == CBMI_PH_HIGH && ph_count == 16'h0000)
      next_rd_data = rom_mem[ROM_AW'(addr - ROM_BASE)];
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      phase <= CBMI_PH_LOW;
      ph_count <= '0;
      addr <= '0;
      rw <= 1'b1;
      tgt <= CBMI_TGT_NONE;
      rd_data <= '0;
      drive <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      ph_count <= next_ph_count;
      addr <= next_addr;
      rw <= next_rw;
      tgt <= next_tgt;
      rd_data <= next_rd_data;
      drive <= next_drive;
    end
  end

  assign cpu_phase_two_clock_out = (phase == CBMI_PH_HIGH);
  assign cpu_reset_n_out = cpu_reset_n;
  // Buffer on only in the low half; it floats in the high half for data
  assign addr_buffer_enable_n_out = (phase == CBMI_PH_HIGH) || !running;
  assign sram_select_n_out = !(tgt == CBMI_TGT_SRAM);
  assign io_select_n_out = !(tgt == CBMI_TGT_IO);
  assign shared_addr_data_pin_low_out = rd_data;
  assign shared_addr_data_oe_out = drive;
  assign image_req_out = image_req;
  assign image_addr_out = copy_addr;
  assign boot_done_out = running;
endmodule : cbmi_bus_mux
`default_nettype wire

// File: rtl/cbmi_defines.svh
// Constants for the processor bus multiplexer block
`ifndef CBMI_DEFINES_SVH
`define CBMI_DEFINES_SVH
`define CBMI_CLK_MHZ 125
`define CBMI_CORE_XTAL_MHZ 5
`define CBMI_CORE_PLL_MULT 16
`define CBMI_PHASE_HALF_NS 500
`define CBMI_PHASE_HALF_CYC ((`CBMI_PHASE_HALF_NS * `CBMI_CLK_MHZ) / 1000)
`define CBMI_RESET_PULSE_NS 20000
`define CBMI_RESET_PULSE_CYC ((`CBMI_RESET_PULSE_NS * `CBMI_CLK_MHZ) / 1000)
`define CBMI_BOOT_WAIT_NS 1000
`define CBMI_BOOT_WAIT_CYC ((`CBMI_BOOT_WAIT_NS * `CBMI_CLK_MHZ) / 1000)
`define CBMI_IMAGE_BYTES 32768
`define CBMI_ROM_BASE 16'hE000
`define CBMI_SRAM_TOP 16'h9FFF
`define CBMI_IO_BASE 16'hA000
`define CBMI_IO_TOP 16'hA0FF
`define CBMI_ADDR_RELEASE_CYC 2
`define CBMI_DATA_RELEASE_CYC 2
`endif

// File: rtl/cbmi_pkg.sv
// Types for the processor bus multiplexer block
package cbmi_pkg;
  typedef enum logic [1:0] {CBMI_TGT_NONE, CBMI_TGT_SRAM, CBMI_TGT_IO, CBMI_TGT_ROM} cbmi_target_t;
  typedef enum {CBMI_ST_BOOT_WAIT, CBMI_ST_COPY, CBMI_ST_RESET, CBMI_ST_RUN} cbmi_state_t;
  typedef enum {CBMI_PH_LOW, CBMI_PH_HIGH} cbmi_phase_t;
endpackage : cbmi_pkg

// File: rtl/cbmi_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module cbmi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end
  assign sync_out = stage2;
endmodule : cbmi_sync
`default_nettype wire

// File: sim/cbmi_bus_mux_sva.sv
// Port assertions for the processor bus multiplexer
`timescale 1ns/10ps
`default_nettype none
module cbmi_bus_mux_sva #(
  parameter int PHASE_HALF_CYC = 62,
  parameter int IMAGE_BYTES = 32768
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic image_valid_in,
  input wire logic image_req_out,
  input wire logic [14:0] image_addr_out,
  input wire logic shared_addr_data_oe_out,
  input wire logic cpu_phase_two_clock_out,
  input wire logic cpu_reset_n_out,
  input wire logic addr_buffer_enable_n_out,
  input wire logic sram_select_n_out,
  input wire logic io_select_n_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic ph_q, next_ph_q, seen, next_seen;
  int cnt, next_cnt;
  // The first half period after reset is unmeasured, so it is skipped
  wire flip = cpu_phase_two_clock_out != ph_q;
  always_comb
  begin
    next_ph_q = cpu_phase_two_clock_out;
    next_seen = seen | flip;
    next_cnt = flip ? 0 : cnt + 1;
  end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ph_q <= 1'h0;
      seen <= 1'h0;
      cnt <= 0;
    end
    else
    begin
      ph_q <= next_ph_q;
      seen <= next_seen;
      cnt <= next_cnt;
    end
  end
  property p_buf_off;
    cpu_phase_two_clock_out |-> addr_buffer_enable_n_out;
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffer on in high half");
  property p_oe_only;
    shared_addr_data_oe_out |-> cpu_phase_two_clock_out && addr_buffer_enable_n_out;
  endproperty
  a_oe_only: assert property (p_oe_only) else $error("pins driven out of turn");
  property p_oe_rel;
    $fell(cpu_phase_two_clock_out) |-> !$past(shared_addr_data_oe_out, 2);
  endproperty
  a_oe_rel: assert property (p_oe_rel) else $error("late data release");
  property p_sel_high;
    !(sram_select_n_out && io_select_n_out) |->
      cpu_phase_two_clock_out && (sram_select_n_out || io_select_n_out);
  endproperty
  a_sel_high: assert property (p_sel_high) else $error("bad select");
  property p_sel_hold;
    cpu_phase_two_clock_out && $past(cpu_phase_two_clock_out) |->
      $stable({sram_select_n_out, io_select_n_out});
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved");
  property p_half;
    flip && seen |-> cnt == PHASE_HALF_CYC - 1;
  endproperty
  a_half: assert property (p_half) else $error("phase half length wrong");
  property p_img_step;
    image_req_out && image_valid_in && image_addr_out != 15'(IMAGE_BYTES - 1) |=>
      image_addr_out == $past(image_addr_out) + 15'h1;
  endproperty
  a_img_step: assert property (p_img_step) else $error("image index step");
  property p_copy_rst;
    image_req_out |-> !cpu_reset_n_out;
  endproperty
  a_copy_rst: assert property (p_copy_rst) else $error("processor free in copy");
endmodule : cbmi_bus_mux_sva
bind cbmi_bus_mux cbmi_bus_mux_sva #(.PHASE_HALF_CYC(PHASE_HALF_CYC),
  .IMAGE_BYTES(IMAGE_BYTES)) i_cbmi_bus_mux_sva (.*);
`default_nettype wire

// File: sim/cbmi_cpu_model.sv
// Processor side of the shared address and data pins
`timescale 1ns/10ps
`default_nettype none
module cbmi_cpu_model (
  input wire logic clk_in,
  input wire logic ph_in,
  input wire logic off_n_in,
  input wire logic oe_in,
  input wire logic [7:0] dq_in,
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  input wire logic [7:0] wd_in,
  output logic [7:0] low_out,
  output logic [7:0] top_out
);
  logic [7:0] last = 8'h0;
  assign top_out = addr_in[15:8];
  always_comb
  begin
    if (!off_n_in && oe_in)
      low_out = 8'hXX;
    else if (!off_n_in)
      low_out = addr_in[7:0];
    else if (oe_in)
      low_out = dq_in;
    else if (ph_in && !rd_in)
      low_out = wd_in;
    else
      low_out = ~last;
  end
  // Remember only driven values so a released bus shows their inverse
  always @(posedge clk_in)
    if (!off_n_in || oe_in || (ph_in && !rd_in))
      last <= low_out;
endmodule : cbmi_cpu_model
`default_nettype wire

// File: sim/tb_cpu_bus_mux_interface.sv
// Self-checking bench for the processor bus multiplexer
`timescale 1ns/10ps
`default_nettype none
`include "cbmi_defines.svh"
module tb_cpu_bus_mux_interface;
  logic clk_in = 1'h0, rst_n_in = 1'h0, core_clock_locked_in = 1'h0;
  logic download_active_in = 1'h1, image_valid_in = 1'h0, image_req_out, boot_done_out;
  logic shared_addr_data_oe_out, cpu_phase_two_clock_out, cpu_reset_n_out;
  logic addr_buffer_enable_n_out, sram_select_n_out, io_select_n_out, rd = 1'h1;
  logic [14:0] image_addr_out;
  logic [7:0] image_byte_in, shared_addr_data_pin_low_in, shared_addr_data_pin_low_out;
  logic [7:0] bus_pin_group_top_in, wd = 8'h0;
  logic [7:0] img [16];
  logic [15:0] ad = 16'h0, ra;
  logic [15:0] fix [9] = '{16'h0000, 16'h9FFF, 16'hA000, 16'hA0FF, 16'hA100, 16'hDFFF,
    16'hE000, 16'hE007, 16'hE003};
  int n_mismatch = 0, compares = 0, seed = 32'h06821E3D;
  wire cpu_read_write_strobe_in = rd;
  always #4 clk_in = ~clk_in;
  // Stalls in the image source exercise the copy handshake
  assign image_byte_in = image_valid_in ? img[image_addr_out[3:0]] : ~image_addr_out[7:0];
  always @(posedge clk_in)
    image_valid_in <= image_req_out && ($random(seed) % 4 != 0);
  cbmi_bus_mux #(.PHASE_HALF_CYC(8), .RESET_PULSE_CYC(4), .BOOT_WAIT_CYC(2),
    .IMAGE_BYTES(16), .ROM_BYTES(8)) i_cbmi_bus_mux (.*);
  cbmi_cpu_model i_cbmi_cpu_model (.clk_in(clk_in), .ph_in(cpu_phase_two_clock_out),
    .off_n_in(addr_buffer_enable_n_out), .oe_in(shared_addr_data_oe_out),
    .dq_in(shared_addr_data_pin_low_out), .addr_in(ad), .rd_in(rd), .wd_in(wd),
    .low_out(shared_addr_data_pin_low_in), .top_out(bus_pin_group_top_in));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task automatic wait_ph(input logic lvl);
    for (int i = 0; i < 40 && cpu_phase_two_clock_out !== lvl; i++)
      @(negedge clk_in);
    check("phase", cpu_phase_two_clock_out, lvl);
  endtask : wait_ph
  task automatic boot();
    rst_n_in <= 1'h0;
    core_clock_locked_in <= 1'h0;
    download_active_in <= 1'h1;
    repeat (2)
      @(posedge clk_in);
    rst_n_in <= 1'h1;
    repeat (12)
      @(posedge clk_in);
    @(negedge clk_in);
    check("req_unlocked", image_req_out, 1'h0);
    @(posedge clk_in);
    core_clock_locked_in <= 1'h1;
    repeat (12)
      @(posedge clk_in);
    @(negedge clk_in);
    check("req_download", image_req_out, 1'h0);
    @(posedge clk_in);
    download_active_in <= 1'h0;
    for (int i = 0; i < 300 && boot_done_out !== 1'h1; i++)
      @(negedge clk_in);
    // The processor reset is released one clock after running starts
    @(negedge clk_in);
    check("cpu_rst_n", cpu_reset_n_out, 1'h1);
  endtask : boot
  task automatic bus(input logic [15:0] a, input logic r);
    logic rom;
    rom = r && a >= `CBMI_ROM_BASE;
    wait_ph(1'h1);
    wait_ph(1'h0);
    @(posedge clk_in);
    ad <= a;
    rd <= r;
    wd <= 8'($random(seed));
    repeat (3)
      @(negedge clk_in);
    check("low_pins", shared_addr_data_pin_low_in, a[7:0]);
    wait_ph(1'h1);
    @(negedge clk_in);
    check("sram_sel_n", sram_select_n_out, a > `CBMI_SRAM_TOP);
    check("io_sel_n", io_select_n_out, !(a >= `CBMI_IO_BASE && a <= `CBMI_IO_TOP));
    check("oe", shared_addr_data_oe_out, rom);
    check("buf_off", addr_buffer_enable_n_out, 1'h1);
    if (rom || !r)
      check("data", shared_addr_data_pin_low_in, rom ? img[{1'h1, a[2:0]}] : wd);
    @(posedge clk_in);
  endtask : bus
  initial
  begin
    for (int i = 0; i < 16; i++)
      img[i] = 8'($random(seed));
    repeat (2)
    begin
      boot();
      foreach (fix[i])
      begin
        bus(fix[i], 1'h1);
        bus(fix[i], 1'h0);
      end
      for (int k = 0; k < 12; k++)
      begin
        ra = 16'($random(seed));
        bus(ra >= `CBMI_ROM_BASE ? {13'h1C00, ra[2:0]} : ra, 1'($random(seed)));
      end
    end
    final_report();
  end
  initial
  begin
    repeat (20000)
      @(posedge clk_in);
    n_mismatch++;
    final_report();
  end
endmodule : tb_cpu_bus_mux_interface
`default_nettype wire
